// ==== hw/aaop_pkg.sv ====
// Purpose: Constants for the add and logical AND execution block.
// Assumes: 8-bit operands, flags C Z S V D H held in one byte.
// Notes:
// How it works
// - Addition writes the two's complement 8-bit sum of source and destination.
// - Neither operation writes the source location; only the destination changes.
// - Addition sets carry on carry out of bit 7, else clears it.
// - Addition and AND set zero when the 8-bit result is zero.
// - Addition sets sign when result bit 7 is one.
// - Addition sets overflow when same-sign operands give an opposite-sign result.
// - Addition always clears the decimal-adjust flag.
// - Addition sets half-carry on carry out of the low nibble.
// - AND stores one only where both operand bits are one.
// - AND copies result bit 7 into the sign flag.
// - AND always clears the overflow flag.
package aaop_pkg;
    localparam logic [7:0] OPC_ADD_RR  = 8'h02;
    localparam logic [7:0] OPC_ADD_RIR = 8'h03;
    localparam logic [7:0] OPC_ADD_GG  = 8'h04;
    localparam logic [7:0] OPC_ADD_GIG = 8'h05;
    localparam logic [7:0] OPC_ADD_IMM = 8'h06;
    localparam logic [7:0] OPC_AND_RR  = 8'h52;
    localparam logic [7:0] OPC_AND_RIR = 8'h53;
    localparam logic [7:0] OPC_AND_GG  = 8'h54;
    localparam logic [7:0] OPC_AND_GIG = 8'h55;
    localparam logic [7:0] OPC_AND_IMM = 8'h56;
    // Flag bit positions in the flag byte
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam int FLG_V = 4;
    localparam int FLG_D = 3;
    localparam int FLG_H = 2;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    // Instruction lengths and cycle counts
    localparam logic [1:0] LEN_SHORT = 2'h2;
    localparam logic [1:0] LEN_LONG  = 2'h3;
    localparam logic [3:0] CYC_SHORT = 4'h4;
    localparam logic [3:0] CYC_LONG  = 4'h6;
    typedef enum logic [1:0] {AAOP_ADD, AAOP_AND, AAOP_NONE} aaop_op_e;
endpackage

// ==== hw/aaop_alu.sv ====
// Purpose: Executes add and logical AND, producing result, flags, length and cycle count.
// Assumes: Operands are fetched by the core; byte2/byte3 are the instruction bytes.
// Notes: Result takes one mclk after issue; illegal opcodes leave state untouched.
`timescale 1ns/10ps
`default_nettype none
module aaop_alu
    import aaop_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // Issue
    input  wire logic       issue,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] byte2,
    input  wire logic [7:0] byte3,
    input  wire logic [7:0] dst_val,
    input  wire logic [7:0] src_val,
    input  wire logic [7:0] flags_in,
    // Decode outputs
    output logic            immediate_operand_mode,
    output logic [7:0]      src_addr,
    output logic [7:0]      dst_addr,
    // Results
    output logic            done,
    output logic            dst_we,
    output logic            src_we,
    output logic [7:0]      result,
    output logic [7:0]      flags_out,
    output logic [1:0]      inst_len,
    output logic [3:0]      inst_cycles,
    output logic            illegal
);
    aaop_op_e   op;
    logic       long_form;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] next_res;
    logic [7:0] next_flags;

    // Opcode decode
    always_comb
    begin
        op        = AAOP_NONE;
        long_form = 1'b0;
        case (opcode)
            OPC_ADD_RR, OPC_ADD_RIR:               op = AAOP_ADD;
            OPC_ADD_GG, OPC_ADD_GIG, OPC_ADD_IMM:
            begin
                op        = AAOP_ADD;
                long_form = 1'b1;
            end
            OPC_AND_RR, OPC_AND_RIR:               op = AAOP_AND;
            OPC_AND_GG, OPC_AND_GIG, OPC_AND_IMM:
            begin
                op        = AAOP_AND;
                long_form = 1'b1;
            end
            default:                               op = AAOP_NONE;
        endcase
    end

    // Operand addresses; working-register forms pack dst in high nibble, src low
    always_comb
    begin
        immediate_operand_mode = (opcode == OPC_ADD_IMM) || (opcode == OPC_AND_IMM);
        if (!long_form)
        begin
            dst_addr = {4'h0, byte2[7:4]};
            src_addr = {4'h0, byte2[3:0]};
        end
        else if (immediate_operand_mode)
        begin
            dst_addr = byte2;
            src_addr = DATA_RST;
        end
        else
        begin
            src_addr = byte2;
            dst_addr = byte3;
        end
    end

    // Arithmetic and flag computation
    always_comb
    begin
        sum        = {1'b0, dst_val} + {1'b0, src_val};
        nib        = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]};
        next_res   = dst_val;
        next_flags = flags_in;
        if (op == AAOP_ADD)
        begin
            next_res          = sum[7:0];
            next_flags[FLG_C] = sum[8];
            next_flags[FLG_S] = sum[7];
            next_flags[FLG_V] = (dst_val[7] == src_val[7]) && (sum[7] != dst_val[7]);
            next_flags[FLG_D] = 1'b0;
            next_flags[FLG_H] = nib[4];
        end
        else if (op == AAOP_AND)
        begin
            next_res          = dst_val & src_val;
            next_flags[FLG_S] = next_res[7];
            next_flags[FLG_V] = 1'b0;
        end
        next_flags[FLG_Z] = (op == AAOP_NONE) ? flags_in[FLG_Z] : (next_res == 8'h00);
    end

    // Registered results; C, D, H pass through for AND
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            done        <= 1'b0;
            dst_we      <= 1'b0;
            result      <= DATA_RST;
            flags_out   <= FLAGS_RST;
            inst_len    <= 2'h0;
            inst_cycles <= 4'h0;
            illegal     <= 1'b0;
        end
        else
        begin
            done    <= issue;
            dst_we  <= issue && (op != AAOP_NONE);
            illegal <= issue && (op == AAOP_NONE);
            if (issue && op != AAOP_NONE)
            begin
                result      <= next_res;
                flags_out   <= next_flags;
                inst_len    <= long_form ? LEN_LONG : LEN_SHORT;
                inst_cycles <= (long_form || opcode[0]) ? CYC_LONG : CYC_SHORT;
            end
        end
    end

    // The source location is never written back
    assign src_we = 1'b0;

    // Issue cycles as named steps; every check built on them looks one edge past the issue
    sequence s_add_issue;
        issue && op == AAOP_ADD;
    endsequence
    sequence s_and_issue;
        issue && op == AAOP_AND;
    endsequence
    sequence s_legal_issue;
        issue && op != AAOP_NONE;
    endsequence
    sequence s_bad_issue;
        issue && op == AAOP_NONE;
    endsequence

    // Sum is checked against its own addition, not the design's sum net
    property p_add_sum;
        @(posedge mclk) disable iff (srst)
        s_add_issue |=> result == 8'($past(dst_val) + $past(src_val));
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("add sum wrong");
    property p_no_src;
        @(posedge mclk) disable iff (srst) done |-> !src_we;
    endproperty
    a_no_src: assert property (p_no_src) else $error("source written");
    property p_carry;
        @(posedge mclk) disable iff (srst)
        issue && op == AAOP_ADD |=> flags_out[FLG_C] == $past(sum[8]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");
    property p_zero;
        @(posedge mclk) disable iff (srst) dst_we |-> flags_out[FLG_Z] == (result == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_ovf;
        @(posedge mclk) disable iff (srst) issue && op == AAOP_ADD |=>
        flags_out[FLG_V] == ($past(dst_val[7]) == $past(src_val[7])
                             && result[7] != $past(dst_val[7]));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow wrong");
    property p_dclr;
        @(posedge mclk) disable iff (srst) issue && op == AAOP_ADD |=> !flags_out[FLG_D];
    endproperty
    a_dclr: assert property (p_dclr) else $error("decimal flag not cleared");
    property p_and;
        @(posedge mclk) disable iff (srst) issue && op == AAOP_AND |=>
        result == ($past(dst_val) & $past(src_val)) && !flags_out[FLG_V]
        && flags_out[FLG_S] == result[7];
    endproperty
    a_and: assert property (p_and) else $error("and result wrong");
    property p_keep;
        @(posedge mclk) disable iff (srst) issue && op == AAOP_AND |=>
        flags_out[FLG_C] == $past(flags_in[FLG_C]) && flags_out[FLG_D] == $past(flags_in[FLG_D])
        && flags_out[FLG_H] == $past(flags_in[FLG_H]);
    endproperty
    a_keep: assert property (p_keep) else $error("and changed kept flags");

    // Flag checks split out so a broken single flag names itself
    property p_sign;
        @(posedge mclk) disable iff (srst) s_add_issue |=> flags_out[FLG_S] == result[7];
    endproperty
    a_sign: assert property (p_sign) else $error("add sign flag wrong");
    property p_half;
        @(posedge mclk) disable iff (srst) s_add_issue |=>
        flags_out[FLG_H] == (({1'b0, $past(dst_val[3:0])} + {1'b0, $past(src_val[3:0])}) > 5'h0F);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");
    property p_and_sign;
        @(posedge mclk) disable iff (srst) s_and_issue |=> flags_out[FLG_S] == result[7];
    endproperty
    a_and_sign: assert property (p_and_sign) else $error("and sign flag wrong");
    property p_and_ovf;
        @(posedge mclk) disable iff (srst) s_and_issue |=> !flags_out[FLG_V];
    endproperty
    a_and_ovf: assert property (p_and_ovf) else $error("and overflow not cleared");

    // Length follows opcode bit 2; only the x2 opcodes are the short 4-cycle forms
    property p_len;
        @(posedge mclk) disable iff (srst) s_legal_issue |=>
        inst_len == ($past(opcode[2]) ? LEN_LONG : LEN_SHORT)
        && inst_cycles == (($past(opcode[3:0]) == 4'h2) ? CYC_SHORT : CYC_LONG);
    endproperty
    a_len: assert property (p_len) else $error("length or cycles wrong");

    // A refused opcode must not disturb the last stored result or flags
    property p_refuse;
        @(posedge mclk) disable iff (srst) s_bad_issue |=>
        illegal && !dst_we && $stable(result) && $stable(flags_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("illegal opcode changed state");

    // Every issue answers exactly one edge later; the write strobe only for legal ones
    property p_done;
        @(posedge mclk) disable iff (srst)
        issue |=> done && (dst_we == !illegal);
    endproperty
    a_done: assert property (p_done) else $error("issue not answered");

    // Long register forms take source from byte 2 and destination from byte 3
    property p_addr_long;
        @(posedge mclk) disable iff (srst)
        issue && opcode[2] && (op != AAOP_NONE) && !immediate_operand_mode |->
        src_addr == byte2 && dst_addr == byte3;
    endproperty
    a_addr_long: assert property (p_addr_long) else $error("long form address wrong");
    property p_addr_imm;
        @(posedge mclk) disable iff (srst)
        issue && immediate_operand_mode |-> dst_addr == byte2;
    endproperty
    a_addr_imm: assert property (p_addr_imm) else $error("immediate dst address wrong");
endmodule
`default_nettype wire

// ==== verif/add_and_alu_ops_tb.sv ====
// Purpose: Self-checking bench for the add and logical AND execution block.
// Assumes: Inputs change 1 ns after the rising mclk edge; flag bits 1:0 are not predicted.
// Notes: An integer reference model predicts every registered output on every cycle.
`timescale 1ns/10ps
`default_nettype none
module add_and_alu_ops_tb
    import aaop_pkg::*;
;
    logic       mclk, srst, issue, imm_mode, done, dst_we, src_we, illegal, is_and;
    logic [7:0] opcode, byte2, byte3, dst_val, src_val, flags_in;
    logic [7:0] src_addr, dst_addr, result, flags_out, e_res, e_flg, e_len, e_cyc;
    logic [1:0] inst_len;
    logic [3:0] inst_cycles;
    logic       e_done, e_ill;
    int         err_count, tests_run, cyc, sum;
    logic [7:0] opc_tbl [11] = '{OPC_ADD_RR, OPC_ADD_RIR, OPC_ADD_GG, OPC_ADD_GIG, OPC_ADD_IMM,
        OPC_AND_RR, OPC_AND_RIR, OPC_AND_GG, OPC_AND_GIG, OPC_AND_IMM, 8'h07};

    aaop_alu u_dut (.mclk(mclk), .srst(srst), .issue(issue), .opcode(opcode), .byte2(byte2),
        .byte3(byte3), .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in),
        .immediate_operand_mode(imm_mode), .src_addr(src_addr), .dst_addr(dst_addr),
        .done(done), .dst_we(dst_we), .src_we(src_we), .result(result), .flags_out(flags_out),
        .inst_len(inst_len), .inst_cycles(inst_cycles), .illegal(illegal));

    // 25 MHz clock
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // Hang guard, sized well above the 432 cycles the sequence needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Registered outputs return to zero, so the model restarts from zero too
    task automatic do_reset();
        srst = 1'b1;
        issue = 1'b0;
        repeat (16) @(posedge mclk);
        #1 srst = 1'b0;
        {e_res, e_flg, e_len, e_cyc, e_done, e_ill} = '0;
    endtask

    // Results stand until the next legal issue, so every cycle is compared
    task automatic check_outputs();
        chk({7'h00, done}, {7'h00, e_done | e_ill}, "done");
        chk({7'h00, dst_we}, {7'h00, e_done}, "dst_we");
        chk({7'h00, src_we}, 8'h00, "src_we");
        chk({7'h00, illegal}, {7'h00, e_ill}, "illegal");
        chk(result, e_res, "result");
        chk({7'h00, flags_out[FLG_C]}, {7'h00, e_flg[FLG_C]}, "C");
        chk({7'h00, flags_out[FLG_Z]}, {7'h00, e_flg[FLG_Z]}, "Z");
        chk({7'h00, flags_out[FLG_S]}, {7'h00, e_flg[FLG_S]}, "S");
        chk({7'h00, flags_out[FLG_V]}, {7'h00, e_flg[FLG_V]}, "V");
        chk({7'h00, flags_out[FLG_D]}, {7'h00, e_flg[FLG_D]}, "D");
        chk({7'h00, flags_out[FLG_H]}, {7'h00, e_flg[FLG_H]}, "H");
        chk({6'h00, inst_len}, e_len, "len");
        chk({4'h0, inst_cycles}, e_cyc, "cycles");
    endtask

    // First eleven issues walk the opcode table, then random traffic with a one-in-four chance of an idle cycle
    task automatic drive(input int i);
        int k;
        k = (i < 11) ? i : $urandom_range(10);
        issue = (i < 11) || ($urandom_range(3) != 0);
        opcode = opc_tbl[k];
        {byte2, byte3, dst_val, flags_in} = $urandom;
        src_val = (i % 16 == 5) ? 8'h00 - dst_val : 8'($urandom);
        e_done = issue && (k < 10);
        e_ill = issue && (k == 10);
        if (e_done)
        begin
            is_and = (k > 4);
            sum = dst_val + src_val;
            e_res = is_and ? (dst_val & src_val) : 8'(sum);
            e_flg[FLG_C] = is_and ? flags_in[FLG_C] : (sum > 255);
            e_flg[FLG_Z] = (e_res == 8'h00);
            e_flg[FLG_S] = e_res[7];
            e_flg[FLG_V] = !is_and && (dst_val[7] == src_val[7]) && (e_res[7] != dst_val[7]);
            e_flg[FLG_D] = is_and && flags_in[FLG_D];
            e_flg[FLG_H] = is_and ? flags_in[FLG_H] : ((dst_val % 16 + src_val % 16) > 15);
            e_len = (k % 5 < 2) ? 8'h02 : 8'h03;
            e_cyc = (k % 5 == 0) ? 8'h04 : 8'h06;
            #1;
            if (k % 5 < 2)
            begin
                chk(dst_addr, {4'h0, byte2[7:4]}, "dst_addr");
                chk(src_addr, {4'h0, byte2[3:0]}, "src_addr");
            end
            else
            begin
                chk(dst_addr, (k % 5 == 4) ? byte2 : byte3, "dst_addr");
                chk(src_addr, (k % 5 == 4) ? 8'h00 : byte2, "src_addr");
            end
            chk({7'h00, imm_mode}, {7'h00, k % 5 == 4}, "imm mode");
        end
    endtask

    // Main sequence with a second reset in mid-run
    initial
    begin
        {srst, issue, opcode, byte2, byte3, dst_val, src_val, flags_in} = '0;
        {err_count, tests_run, cyc} = '0;
        void'($urandom(40));
        do_reset();
        for (int i = 0; i < 400; i++)
        begin
            @(posedge mclk);
            #1;
            check_outputs();
            if (i == 200)
            begin
                do_reset();
                check_outputs();
            end
            drive(i);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
